// >>> rtl/erw_pkg.sv
package erw_pkg;

  // Window selector carried with each system-register access
  typedef enum logic [2:0] {
    WIN_CTRL = 3'b000,
    WIN_FEAT = 3'b001,
    WIN_STATUS = 3'b010,
    WIN_MISC0 = 3'b011,
    WIN_MISC1 = 3'b100,
    WIN_VDEFER = 3'b101,
    WIN_DEFER = 3'b110,
    WIN_DEFER_NARROW = 3'b111
  } erw_win_t;

  // Outcome of an access
  typedef enum logic [2:0] {
    RES_OK = 3'b000,
    RES_UNDEF = 3'b001,
    RES_TRAP_EL2 = 3'b010,
    RES_TRAP_EL3 = 3'b011,
    RES_PHYS = 3'b100
  } erw_res_t;

  // Privilege level codes
  localparam logic [1:0] EL_USER = 2'h0;
  localparam logic [1:0] EL_KERNEL = 2'h1;
  localparam logic [1:0] EL_HYP = 2'h2;
  localparam logic [1:0] EL_MON = 2'h3;

  // Virtual deferred status layout
  localparam int DEF_FLAG_BIT = 31;
  localparam int IMPL_SYN_BIT = 24;
  localparam int ERR_TYPE_HI = 15;
  localparam int ERR_TYPE_LO = 14;
  localparam int ABORT_TYPE_BIT = 12;
  localparam int FAULT_HI_BIT = 10;
  localparam int LONG_FMT_BIT = 9;
  localparam logic [4:0] SHORT_FAULT_CODE = 5'h16;
  localparam logic [5:0] LONG_STATUS_CODE = 6'h11;
  localparam logic [63:0] VDEF_WRITE_MASK = 64'h0000_0000_81FF_FFFF;
  localparam logic [63:0] VDEF_RESET = 64'h0000_0000_0000_0000;

  // Error record contents after reset
  localparam logic [63:0] RECORD_RESET = 64'h0000_0000_0000_0000;

endpackage

// >>> rtl/erw_regs.sv
`timescale 1ns/100ps
module erw_regs #(
  parameter int NUM_RECORDS = 4,
  parameter logic [63:0] FEATURE_VAL = 64'h0000_0000_0000_0000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Configuration of the processor element
  input wire logic ras_present,
  input wire logic el2_present,
  input wire logic el3_present,
  input wire logic el1_narrow,
  input wire logic el1_long_format,
  input wire logic hyp_error_trap,
  input wire logic mon_error_trap,
  input wire logic async_abort_route,
  input wire logic [15:0] record_select,
  input wire logic [15:0] record_count,
  input wire logic [63:0] virt_syndrome,
  // Barrier defers a virtual asynchronous error
  input wire logic barrier_defer,
  // Access request
  input wire logic req_valid,
  input wire logic req_write,
  input wire erw_pkg::erw_win_t req_win,
  input wire logic [1:0] req_el,
  input wire logic req_ns,
  input wire logic [63:0] req_wdata,
  // Access response
  output logic rsp_valid,
  output erw_pkg::erw_res_t rsp_result,
  output logic [63:0] rsp_rdata,
  // Current virtual deferred status
  output logic [63:0] virt_deferred_q
);

  localparam int IDX_W = (NUM_RECORDS > 1) ? $clog2(NUM_RECORDS) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [63:0] rec_ctrl_r [NUM_RECORDS];
  logic [63:0] rec_status_r [NUM_RECORDS];
  logic [63:0] rec_misc0_r [NUM_RECORDS];
  logic [63:0] rec_misc1_r [NUM_RECORDS];
  logic [63:0] vdef_r;
  logic rsp_valid_r;
  erw_pkg::erw_res_t rsp_result_r;
  logic [63:0] rsp_rdata_r;

  logic [IDX_W-1:0] rec_idx;
  logic rec_valid;
  logic win_is_record;
  logic [63:0] vdef_cur;
  logic [63:0] defer_val;
  erw_pkg::erw_res_t res_nxt;
  logic [63:0] rdata_nxt;
  logic rec_we;
  logic vdef_we;
  logic [63:0] vdef_wval;

  // Syndrome layout follows the state of EL1 at the time of the barrier
  function automatic logic [63:0] build_defer(input logic narrow, input logic long_fmt,
                                              input logic [63:0] syn);
    logic [63:0] v;
    v = 64'h0000_0000_0000_0000;
    v[erw_pkg::DEF_FLAG_BIT] = 1'b1;
    if (!narrow) begin
      v[erw_pkg::IMPL_SYN_BIT:0] = syn[erw_pkg::IMPL_SYN_BIT:0];
    end else begin
      v[erw_pkg::ERR_TYPE_HI:erw_pkg::ERR_TYPE_LO] = syn[erw_pkg::ERR_TYPE_HI:erw_pkg::ERR_TYPE_LO];
      v[erw_pkg::ABORT_TYPE_BIT] = syn[erw_pkg::ABORT_TYPE_BIT];
      if (long_fmt) begin
        v[erw_pkg::LONG_FMT_BIT] = 1'b1;
        v[5:0] = erw_pkg::LONG_STATUS_CODE;
      end else begin
        v[erw_pkg::FAULT_HI_BIT] = erw_pkg::SHORT_FAULT_CODE[4];
        v[3:0] = erw_pkg::SHORT_FAULT_CODE[3:0];
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Record selection and decision

  // Selects beyond the implemented records are treated as no record too
  assign rec_idx = record_select[IDX_W-1:0];
  assign rec_valid = (record_count != 16'h0000) && (record_select < record_count)
                     && (record_select < 16'(NUM_RECORDS));
  assign win_is_record = (req_win <= erw_pkg::WIN_MISC1);
  assign defer_val = build_defer(el1_narrow, el1_long_format, virt_syndrome);
  // Forwarding lets a read in the barrier's cycle see the new value
  assign vdef_cur = barrier_defer ? defer_val : vdef_r;

  always_comb begin
    res_nxt = erw_pkg::RES_OK;
    rdata_nxt = 64'h0000_0000_0000_0000;
    rec_we = 1'b0;
    vdef_we = 1'b0;
    vdef_wval = req_wdata & erw_pkg::VDEF_WRITE_MASK;
    if (!ras_present) begin
      res_nxt = erw_pkg::RES_UNDEF;
    end else if (win_is_record) begin
      if (req_el == erw_pkg::EL_USER) begin
        res_nxt = erw_pkg::RES_UNDEF;
      end else if (req_win == erw_pkg::WIN_FEAT && req_write) begin
        res_nxt = erw_pkg::RES_UNDEF;
      end else if (el2_present && hyp_error_trap && req_el == erw_pkg::EL_KERNEL && req_ns) begin
        res_nxt = erw_pkg::RES_TRAP_EL2;
      end else if (el3_present && mon_error_trap
                   && (req_el == erw_pkg::EL_KERNEL || req_el == erw_pkg::EL_HYP)) begin
        res_nxt = erw_pkg::RES_TRAP_EL3;
      end else if (!rec_valid) begin
        rdata_nxt = 64'h0000_0000_0000_0000;
      end else begin
        unique case (req_win)
          erw_pkg::WIN_CTRL: rdata_nxt = rec_ctrl_r[rec_idx];
          erw_pkg::WIN_STATUS: rdata_nxt = rec_status_r[rec_idx];
          erw_pkg::WIN_MISC0: rdata_nxt = rec_misc0_r[rec_idx];
          erw_pkg::WIN_MISC1: rdata_nxt = rec_misc1_r[rec_idx];
          default: rdata_nxt = FEATURE_VAL;
        endcase
        rec_we = req_valid && req_write;
      end
    end else if (req_win == erw_pkg::WIN_VDEFER) begin
      if (req_el == erw_pkg::EL_USER || req_el == erw_pkg::EL_KERNEL) begin
        res_nxt = erw_pkg::RES_UNDEF;
      end else if (!el2_present) begin
        rdata_nxt = 64'h0000_0000_0000_0000;
      end else begin
        rdata_nxt = vdef_cur;
        vdef_we = req_valid && req_write;
      end
    end else begin
      if (req_el == erw_pkg::EL_USER) begin
        res_nxt = erw_pkg::RES_UNDEF;
      end else if (req_el == erw_pkg::EL_KERNEL && req_ns && el2_present && async_abort_route) begin
        if (req_win == erw_pkg::WIN_DEFER_NARROW) begin
          rdata_nxt = {32'h0000_0000, vdef_cur[31:0]};
          vdef_wval = {32'h0000_0000, req_wdata[31:0]} & erw_pkg::VDEF_WRITE_MASK;
        end else begin
          rdata_nxt = vdef_cur;
        end
        vdef_we = req_valid && req_write;
      end else begin
        // The physical deferred status lives outside this block
        res_nxt = erw_pkg::RES_PHYS;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error record windows

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_RECORDS; i++) begin
        rec_ctrl_r[i] <= erw_pkg::RECORD_RESET;
        rec_status_r[i] <= erw_pkg::RECORD_RESET;
        rec_misc0_r[i] <= erw_pkg::RECORD_RESET;
        rec_misc1_r[i] <= erw_pkg::RECORD_RESET;
      end
    end else if (rec_we) begin
      unique case (req_win)
        erw_pkg::WIN_CTRL: rec_ctrl_r[rec_idx] <= req_wdata;
        erw_pkg::WIN_STATUS: rec_status_r[rec_idx] <= req_wdata;
        erw_pkg::WIN_MISC0: rec_misc0_r[rec_idx] <= req_wdata;
        erw_pkg::WIN_MISC1: rec_misc1_r[rec_idx] <= req_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Virtual deferred status

  // The barrier wins over a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      vdef_r <= erw_pkg::VDEF_RESET;
    end else if (barrier_defer) begin
      vdef_r <= defer_val;
    end else if (vdef_we) begin
      vdef_r <= vdef_wval;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rsp_valid_r <= 1'b0;
      rsp_result_r <= erw_pkg::RES_OK;
      rsp_rdata_r <= 64'h0000_0000_0000_0000;
    end else begin
      rsp_valid_r <= req_valid;
      rsp_result_r <= req_valid ? res_nxt : erw_pkg::RES_OK;
      rsp_rdata_r <= (req_valid && !req_write && res_nxt == erw_pkg::RES_OK) ? rdata_nxt
                     : 64'h0000_0000_0000_0000;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp_result = rsp_result_r;
  assign rsp_rdata = rsp_rdata_r;
  assign virt_deferred_q = vdef_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_absent_undef: assert property (req_valid && !ras_present |=> rsp_result == erw_pkg::RES_UNDEF)
    else $error("access without extension not undefined");

  a_resp_timing: assert property (rsp_valid == $past(req_valid))
    else $error("response not exactly one cycle after request");

  a_user_undef: assert property (
    req_valid && ras_present && win_is_record && req_el == erw_pkg::EL_USER
    |=> rsp_valid && rsp_result == erw_pkg::RES_UNDEF)
    else $error("EL0 window access not undefined");

  a_feat_readonly: assert property (
    req_valid && ras_present && req_win == erw_pkg::WIN_FEAT && req_write
    |=> rsp_result == erw_pkg::RES_UNDEF)
    else $error("feature write accepted");

  a_feat_read: assert property (
    req_valid && !req_write && ras_present && req_win == erw_pkg::WIN_FEAT && req_el != erw_pkg::EL_USER
    && !hyp_error_trap && !mon_error_trap && rec_valid
    |=> rsp_result == erw_pkg::RES_OK && rsp_rdata == FEATURE_VAL)
    else $error("feature read wrong");

  a_hyp_trap: assert property (
    req_valid && ras_present && win_is_record && !req_write
    && req_el == erw_pkg::EL_KERNEL && req_ns && el2_present && hyp_error_trap
    |=> rsp_result == erw_pkg::RES_TRAP_EL2)
    else $error("window access not trapped to EL2");

  a_mon_trap: assert property (
    req_valid && ras_present && win_is_record && !req_write
    && req_el == erw_pkg::EL_HYP && el3_present && mon_error_trap
    |=> rsp_result == erw_pkg::RES_TRAP_EL3)
    else $error("window access not trapped to EL3");

  a_mon_kernel: assert property (
    req_valid && ras_present && win_is_record && !req_write
    && req_el == erw_pkg::EL_KERNEL && !req_ns && el3_present && mon_error_trap
    |=> rsp_result == erw_pkg::RES_TRAP_EL3)
    else $error("secure EL1 window access not trapped to EL3");

  a_norecord_raz: assert property (
    req_valid && ras_present && win_is_record && !req_write
    && req_el == erw_pkg::EL_MON && !rec_valid
    |=> rsp_result == erw_pkg::RES_OK && rsp_rdata == 64'h0000_0000_0000_0000)
    else $error("no-record read not zero");

  a_count_zero: assert property (
    req_valid && ras_present && win_is_record && !req_write
    && req_el == erw_pkg::EL_MON && record_count == 16'h0000
    |=> rsp_result == erw_pkg::RES_OK && rsp_rdata == 64'h0000_0000_0000_0000)
    else $error("zero record count still selects a record");

  a_record_read: assert property (
    req_valid && !req_write && ras_present && rec_valid && req_win == erw_pkg::WIN_STATUS
    && req_el == erw_pkg::EL_HYP && !(el3_present && mon_error_trap)
    |=> rsp_result == erw_pkg::RES_OK && rsp_rdata == $past(rec_status_r[rec_idx]))
    else $error("status window not from selected record");

  a_misc_read: assert property (
    req_valid && !req_write && ras_present && rec_valid && req_win == erw_pkg::WIN_MISC0
    && req_el == erw_pkg::EL_HYP && !(el3_present && mon_error_trap)
    |=> rsp_result == erw_pkg::RES_OK && rsp_rdata == $past(rec_misc0_r[rec_idx]))
    else $error("misc window not from selected record");

  a_ctrl_write: assert property (
    req_valid && req_write && rec_we && req_win == erw_pkg::WIN_CTRL
    |=> rec_ctrl_r[$past(rec_idx)] == $past(req_wdata))
    else $error("control window write lost");

  a_vdef_kernel: assert property (
    req_valid && ras_present && req_win == erw_pkg::WIN_VDEFER && req_el == erw_pkg::EL_KERNEL
    |=> rsp_result == erw_pkg::RES_UNDEF)
    else $error("EL1 direct virtual status access allowed");

  a_vdef_write: assert property (
    req_valid && req_write && ras_present && req_win == erw_pkg::WIN_VDEFER
    && req_el == erw_pkg::EL_HYP && el2_present && !barrier_defer
    |=> vdef_r == ($past(req_wdata) & erw_pkg::VDEF_WRITE_MASK))
    else $error("virtual status write not masked");

  a_defer_flag: assert property (
    barrier_defer
    |=> vdef_r[31] && vdef_r[63:32] == 32'h0000_0000 && vdef_r[30:25] == 6'h00)
    else $error("deferred flag or reserved bits wrong");

  a_defer_wide: assert property (
    barrier_defer && !el1_narrow
    |=> vdef_r[24:0] == $past(virt_syndrome[24:0]))
    else $error("wide syndrome not copied");

  a_defer_narrow: assert property (
    barrier_defer && el1_narrow
    |=> vdef_r[24:16] == 9'h000 && vdef_r[13] == 1'b0 && vdef_r[11] == 1'b0 && vdef_r[8:6] == 3'h0
    && vdef_r[15:14] == $past(virt_syndrome[15:14]) && vdef_r[12] == $past(virt_syndrome[12]))
    else $error("narrow syndrome fields wrong");

  a_defer_short: assert property (
    barrier_defer && el1_narrow && !el1_long_format
    |=> {vdef_r[10], vdef_r[3:0]} == erw_pkg::SHORT_FAULT_CODE && vdef_r[24:16] == 9'h000
    && vdef_r[15:14] == $past(virt_syndrome[15:14]))
    else $error("short format syndrome wrong");

  a_defer_long: assert property (
    barrier_defer && el1_narrow && el1_long_format
    |=> vdef_r[9] && vdef_r[5:0] == erw_pkg::LONG_STATUS_CODE && vdef_r[12] == $past(virt_syndrome[12]))
    else $error("long format syndrome wrong");

  a_route_read: assert property (
    req_valid && !req_write && ras_present && req_win == erw_pkg::WIN_DEFER
    && req_el == erw_pkg::EL_KERNEL && req_ns && el2_present && async_abort_route
    |=> rsp_result == erw_pkg::RES_OK && rsp_rdata == vdef_r)
    else $error("routed deferred read not from virtual status");

  a_route_write: assert property (
    req_valid && req_write && ras_present && req_win == erw_pkg::WIN_DEFER_NARROW && req_el == erw_pkg::EL_KERNEL
    && req_ns && el2_present && async_abort_route && !barrier_defer
    |=> vdef_r == {32'h0000_0000, $past(req_wdata[31:0]) & erw_pkg::VDEF_WRITE_MASK[31:0]})
    else $error("routed narrow write did not reach virtual status");

  a_el3_noel2: assert property (
    req_valid && req_write && ras_present && !el2_present && req_win == erw_pkg::WIN_VDEFER
    && req_el == erw_pkg::EL_MON && !barrier_defer
    |=> $stable(vdef_r))
    else $error("virtual status written without EL2");

  a_el3_raz: assert property (
    req_valid && !req_write && ras_present && !el2_present && req_win == erw_pkg::WIN_VDEFER
    && req_el == erw_pkg::EL_MON
    |=> rsp_result == erw_pkg::RES_OK && rsp_rdata == 64'h0000_0000_0000_0000)
    else $error("virtual status without EL2 not zero");

endmodule

// >>> verification/erw_sw_model.sv
`timescale 1ns/100ps
module erw_sw_model (
  // Clock
  input wire logic core_clk,
  // Access request
  output logic req_valid,
  output logic req_write,
  output erw_pkg::erw_win_t req_win,
  output logic [1:0] req_el,
  output logic req_ns,
  output logic [63:0] req_wdata,
  // Access response
  input wire logic rsp_valid,
  input wire erw_pkg::erw_res_t rsp_result,
  input wire logic [63:0] rsp_rdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_win = erw_pkg::WIN_CTRL;
    req_el = 2'h0;
    req_ns = 1'b0;
    req_wdata = 64'h0;
  end

  // One access, answer sampled once it has settled after its edge
  task automatic access(input logic wr, input erw_pkg::erw_win_t w, input logic [1:0] el, input logic ns,
                        input logic [63:0] wd, output erw_pkg::erw_res_t res, output logic [63:0] rd);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_win <= w;
    req_el <= el;
    req_ns <= ns;
    req_wdata <= wd;
    @(posedge core_clk);
    req_valid <= 1'b0;
    // Released data must not keep looking valid
    req_wdata <= ~wd;
    #1;
    res = rsp_result;
    rd = rsp_rdata;
    if (rsp_valid !== 1'b1) begin
      rd = 'x;
    end
  endtask
endmodule

// >>> verification/test_error_record_window_regs.sv
`timescale 1ns/100ps
module test_error_record_window_regs;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ras = 1'b1, el2 = 1'b1, el3 = 1'b1, nar = 1'b0, lng = 1'b0, hyp = 1'b0, mon = 1'b0, rte = 1'b0;
  logic [15:0] sel = 16'h0000;
  logic [15:0] cnt = 16'h0004;
  logic [63:0] syn = 64'h0;
  logic bar = 1'b0;
  logic req_valid, req_write, req_ns, rsp_valid;
  erw_pkg::erw_win_t req_win;
  erw_pkg::erw_res_t rsp_result;
  logic [1:0] req_el;
  logic [63:0] req_wdata, rsp_rdata, vdq;
  int miscompares = 0;
  int checks = 0;
  erw_pkg::erw_win_t wins [4] = '{erw_pkg::WIN_CTRL, erw_pkg::WIN_STATUS, erw_pkg::WIN_MISC0, erw_pkg::WIN_MISC1};
  localparam logic [63:0] FEAT_V = 64'h0000_0000_0F0F_1234;

  always #50 core_clk = ~core_clk;

  erw_regs #(.NUM_RECORDS(4), .FEATURE_VAL(FEAT_V)) u_erw_regs (
    .core_clk(core_clk), .rstn(rstn), .ras_present(ras), .el2_present(el2), .el3_present(el3),
    .el1_narrow(nar), .el1_long_format(lng), .hyp_error_trap(hyp), .mon_error_trap(mon),
    .async_abort_route(rte), .record_select(sel), .record_count(cnt), .virt_syndrome(syn),
    .barrier_defer(bar), .req_valid(req_valid), .req_write(req_write), .req_win(req_win),
    .req_el(req_el), .req_ns(req_ns), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_result(rsp_result), .rsp_rdata(rsp_rdata), .virt_deferred_q(vdq));

  erw_sw_model u_erw_sw_model (
    .core_clk(core_clk), .req_valid(req_valid), .req_write(req_write), .req_win(req_win),
    .req_el(req_el), .req_ns(req_ns), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_result(rsp_result), .rsp_rdata(rsp_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op(input logic wr, input erw_pkg::erw_win_t w, input logic [1:0] el, input logic ns,
                    input logic [63:0] wd, input erw_pkg::erw_res_t er, input logic [63:0] ed);
    erw_pkg::erw_res_t res;
    logic [63:0] rd;
    u_erw_sw_model.access(wr, w, el, ns, wd, res, rd);
    chk({61'h0, res}, {61'h0, er});
    chk(rd, ed);
  endtask

  // Order: ras, el2, el3, narrow, long, hyp trap, mon trap, route
  task automatic cfg(input logic [7:0] c);
    @(posedge core_clk);
    {ras, el2, el3, nar, lng, hyp, mon, rte} <= c;
  endtask

  task automatic defer(input logic [63:0] s, input logic [63:0] e);
    @(posedge core_clk);
    bar <= 1'b1;
    syn <= s;
    @(posedge core_clk);
    bar <= 1'b0;
    #1;
    chk(vdq, e);
  endtask

  function automatic logic [63:0] pat(input int r, input int i);
    pat = {48'hC0DE_0000_0000, r[7:0], i[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    op(0, erw_pkg::WIN_CTRL, erw_pkg::EL_MON, 0, 0, erw_pkg::RES_OK, 64'h0);
    chk(vdq, 64'h0);
    for (int r = 0; r < 2; r++) begin
      @(posedge core_clk) sel <= r[15:0];
      for (int i = 0; i < 4; i++) op(1, wins[i], erw_pkg::EL_MON, 0, pat(r, i), erw_pkg::RES_OK, 64'h0);
    end
    for (int r = 0; r < 2; r++) begin
      @(posedge core_clk) sel <= r[15:0];
      for (int i = 0; i < 4; i++) op(0, wins[i], erw_pkg::EL_HYP, 0, 0, erw_pkg::RES_OK, pat(r, i));
    end
    op(0, erw_pkg::WIN_FEAT, erw_pkg::EL_KERNEL, 0, 0, erw_pkg::RES_OK, FEAT_V);
    op(1, erw_pkg::WIN_FEAT, erw_pkg::EL_MON, 0, '1, erw_pkg::RES_UNDEF, 64'h0);
    op(0, erw_pkg::WIN_STATUS, erw_pkg::EL_USER, 1, 0, erw_pkg::RES_UNDEF, 64'h0);
    op(1, erw_pkg::WIN_MISC0, erw_pkg::EL_USER, 1, 0, erw_pkg::RES_UNDEF, 64'h0);
    op(0, erw_pkg::WIN_MISC0, erw_pkg::EL_MON, 0, 0, erw_pkg::RES_OK, pat(1, 2));
    // Select equal to the count: a no-record access
    @(posedge core_clk) sel <= 16'h0004;
    op(1, erw_pkg::WIN_CTRL, erw_pkg::EL_HYP, 0, '1, erw_pkg::RES_OK, 64'h0);
    op(0, erw_pkg::WIN_CTRL, erw_pkg::EL_HYP, 0, 0, erw_pkg::RES_OK, 64'h0);
    @(posedge core_clk) {cnt, sel} <= 32'h0000_0000;
    op(0, erw_pkg::WIN_STATUS, erw_pkg::EL_MON, 0, 0, erw_pkg::RES_OK, 64'h0);
    @(posedge core_clk) cnt <= 16'h0004;
    op(0, erw_pkg::WIN_CTRL, erw_pkg::EL_MON, 0, 0, erw_pkg::RES_OK, pat(0, 0));
    cfg(8'b1110_0100);
    op(0, erw_pkg::WIN_CTRL, erw_pkg::EL_KERNEL, 1, 0, erw_pkg::RES_TRAP_EL2, 64'h0);
    op(0, erw_pkg::WIN_CTRL, erw_pkg::EL_KERNEL, 0, 0, erw_pkg::RES_OK, pat(0, 0));
    cfg(8'b1110_0010);
    op(0, erw_pkg::WIN_STATUS, erw_pkg::EL_HYP, 0, 0, erw_pkg::RES_TRAP_EL3, 64'h0);
    op(1, erw_pkg::WIN_MISC1, erw_pkg::EL_KERNEL, 1, 0, erw_pkg::RES_TRAP_EL3, 64'h0);
    op(0, erw_pkg::WIN_MISC1, erw_pkg::EL_MON, 0, 0, erw_pkg::RES_OK, pat(0, 3));
    // Both traps armed: the hypervisor trap outranks the monitor trap
    cfg(8'b1110_0110);
    op(0, erw_pkg::WIN_STATUS, erw_pkg::EL_KERNEL, 1, 0, erw_pkg::RES_TRAP_EL2, 64'h0);
    op(0, erw_pkg::WIN_STATUS, erw_pkg::EL_KERNEL, 0, 0, erw_pkg::RES_TRAP_EL3, 64'h0);
    cfg(8'b0110_0000);
    op(0, erw_pkg::WIN_CTRL, erw_pkg::EL_MON, 0, 0, erw_pkg::RES_UNDEF, 64'h0);
    op(0, erw_pkg::WIN_VDEFER, erw_pkg::EL_MON, 0, 0, erw_pkg::RES_UNDEF, 64'h0);
    cfg(8'b1110_0001);
    op(0, erw_pkg::WIN_VDEFER, erw_pkg::EL_KERNEL, 1, 0, erw_pkg::RES_UNDEF, 64'h0);
    op(1, erw_pkg::WIN_VDEFER, erw_pkg::EL_HYP, 0, '1, erw_pkg::RES_OK, 64'h0);
    op(0, erw_pkg::WIN_VDEFER, erw_pkg::EL_HYP, 0, 0, erw_pkg::RES_OK, 64'h81FF_FFFF);
    // Upper syndrome bits set so that any leak into reserved bits shows
    defer(64'hFFFF_FFFF_7FAB_CDEF, 64'h81AB_CDEF);
    op(0, erw_pkg::WIN_DEFER, erw_pkg::EL_KERNEL, 1, 0, erw_pkg::RES_OK, 64'h81AB_CDEF);
    // Barrier and routed read in the same cycle: the read sees the new value
    fork
      defer(64'h0000_0000_0100_0042, 64'h8100_0042);
      op(0, erw_pkg::WIN_DEFER, erw_pkg::EL_KERNEL, 1, 0, erw_pkg::RES_OK, 64'h8100_0042);
    join
    op(0, erw_pkg::WIN_DEFER, erw_pkg::EL_KERNEL, 0, 0, erw_pkg::RES_PHYS, 64'h0);
    cfg(8'b1111_0001);
    defer('1, 64'h8000_D406);
    op(0, erw_pkg::WIN_DEFER_NARROW, erw_pkg::EL_KERNEL, 1, 0, erw_pkg::RES_OK, 64'h8000_D406);
    op(1, erw_pkg::WIN_DEFER_NARROW, erw_pkg::EL_KERNEL, 1, '1, erw_pkg::RES_OK, 64'h0);
    chk(vdq, 64'h0000_0000_81FF_FFFF);
    cfg(8'b1111_1001);
    defer('1, 64'h8000_D211);
    cfg(8'b1111_1000);
    op(0, erw_pkg::WIN_DEFER_NARROW, erw_pkg::EL_KERNEL, 1, 0, erw_pkg::RES_PHYS, 64'h0);
    cfg(8'b1010_0000);
    op(1, erw_pkg::WIN_VDEFER, erw_pkg::EL_MON, 0, '1, erw_pkg::RES_OK, 64'h0);
    chk(vdq, 64'h0000_0000_8000_D211);
    op(0, erw_pkg::WIN_VDEFER, erw_pkg::EL_MON, 0, 0, erw_pkg::RES_OK, 64'h0);
    print_verdict();
  end
endmodule
